/* File: hw/dtcr_defs.vh */
// register map, field positions and constants for the dual timer block
`ifndef DTCR_DEFS_VH
`define DTCR_DEFS_VH
`define DTCR_W 16
`define DTCR_ADDR_W 12
// byte addresses of the registers
`define DTCR_A_AUX_CTRL 12'h000
`define DTCR_A_CORE_CTRL 12'h004
`define DTCR_A_AUX_CNT 12'h008
`define DTCR_A_CORE_CNT 12'h00C
`define DTCR_A_CAPTURE_RELOAD_REGISTER 12'h010
`define DTCR_A_CAP_CTRL 12'h014
`define DTCR_A_IRQ_STAT 12'h018
`define DTCR_A_IRQ_MASK 12'h01C
// timer control fields
`define DTCR_F_RUN 0
`define DTCR_F_DOWN 1
`define DTCR_F_EXTDIR 2
`define DTCR_F_SRC_LO 3
`define DTCR_F_SRC_HI 4
`define DTCR_F_PRE_LO 5
`define DTCR_F_PRE_HI 7
`define DTCR_F_EDGE_LO 8
`define DTCR_F_EDGE_HI 9
`define DTCR_F_RLD_EN 10
`define DTCR_F_OUT_EN 11
`define DTCR_CTRL_W 12
// count sources
`define DTCR_SRC_PRE 2'h0
`define DTCR_SRC_EXT 2'h1
`define DTCR_SRC_OTL 2'h2
// capture control fields
`define DTCR_F_CAP_EDGE_LO 0
`define DTCR_F_CAP_EDGE_HI 1
`define DTCR_F_CAP_CLR 2
`define DTCR_F_CAP_SRC_LO 3
`define DTCR_F_CAP_SRC_HI 4
`define DTCR_CAP_CTRL_W 5
// capture sources
`define DTCR_CSRC_PIN 2'h0
`define DTCR_CSRC_FIN 2'h1
`define DTCR_CSRC_FDIR 2'h2
`define DTCR_CSRC_BOTH 2'h3
// interrupt bits
`define DTCR_I_AUX_OVF 0
`define DTCR_I_CORE_OVF 1
`define DTCR_I_CAPTURE 2
`define DTCR_IRQ_W 3
// prescaler: setting 0 gives one count every 2 clocks
`define DTCR_PRE_BASE 2
`define DTCR_PRE_CNT_W 10
`endif

/* File: hw/dtcr_sync.v */
// three-stage input synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module dtcr_sync (
	input wire clk_i,
	input wire srst_i,
	input wire async_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg lvl_q;
	// level moves only when stages two and three agree
	always @(posedge clk_i) begin
		if (srst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				lvl_q <= s3_q;
		end
	end
	assign level_o = lvl_q;
	assign rise_o = (s2_q == s3_q) && s3_q && !lvl_q;
	assign fall_o = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // dtcr_sync
`default_nettype wire

/* File: hw/dtcr_timer.v */
// one 16-bit up/down timer with prescaler and source select
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_defs.vh"
module dtcr_timer (
	input wire clk_i,
	input wire srst_i,
	input wire [`DTCR_CTRL_W-1:0] ctrl_i,
	input wire ext_rise_i,
	input wire ext_fall_i,
	input wire dir_lvl_i,
	input wire otl_rise_i,
	input wire otl_fall_i,
	input wire load_i,
	input wire [`DTCR_W-1:0] load_val_i,
	input wire clear_i,
	output wire [`DTCR_W-1:0] count_o,
	output wire wrap_o
);
	reg [`DTCR_W-1:0] cnt_q;
	reg [`DTCR_PRE_CNT_W-1:0] pre_q;
	wire [2:0] pre_sel;
	wire [1:0] src;
	wire [1:0] edge_sel;
	wire [`DTCR_PRE_CNT_W-1:0] pre_top;
	wire [31:0] pre_full;
	wire pre_tick;
	reg ext_tick;
	wire tick;
	wire down;
	wire run;
	assign pre_sel = ctrl_i[`DTCR_F_PRE_HI:`DTCR_F_PRE_LO];
	assign src = ctrl_i[`DTCR_F_SRC_HI:`DTCR_F_SRC_LO];
	assign edge_sel = ctrl_i[`DTCR_F_EDGE_HI:`DTCR_F_EDGE_LO];
	assign run = ctrl_i[`DTCR_F_RUN];
	// period 2 << pre_sel clocks
	assign pre_full = (`DTCR_PRE_BASE << pre_sel) - 1; // [R1]
	// largest period is 256 clocks, so the low bits hold it all
	assign pre_top = pre_full[`DTCR_PRE_CNT_W-1:0];
	assign pre_tick = (pre_q >= pre_top);
	always @* begin
		ext_tick = 1'b0;
		if (src == `DTCR_SRC_EXT) // [R3]
			ext_tick = (edge_sel[0] && ext_rise_i) ||
				(edge_sel[1] && ext_fall_i);
		else if (src == `DTCR_SRC_OTL) // [R7]
			ext_tick = otl_rise_i || otl_fall_i;
	end
	assign tick = run && ((src == `DTCR_SRC_PRE) ? pre_tick : ext_tick); // [R3]
	// direction pin only honoured when enabled
	assign down = ctrl_i[`DTCR_F_EXTDIR] ?
		(ctrl_i[`DTCR_F_DOWN] ^ dir_lvl_i) : ctrl_i[`DTCR_F_DOWN]; // [R4]
	assign wrap_o = tick && (down ? (cnt_q == {`DTCR_W{1'b0}}) :
		(cnt_q == {`DTCR_W{1'b1}}));
	always @(posedge clk_i) begin
		if (srst_i || !run || pre_tick)
			pre_q <= {`DTCR_PRE_CNT_W{1'b0}};
		else
			pre_q <= pre_q + 1'b1;
	end
	// software or reload write beats counting; clear beats both
	always @(posedge clk_i) begin
		if (srst_i)
			cnt_q <= {`DTCR_W{1'b0}};
		else if (clear_i)
			cnt_q <= {`DTCR_W{1'b0}}; // [R11]
		else if (load_i)
			cnt_q <= load_val_i; // [R14]
		else if (tick)
			cnt_q <= down ? cnt_q - 1'b1 : cnt_q + 1'b1; // [R13]
	end
	assign count_o = cnt_q;
endmodule // dtcr_timer
`default_nettype wire

/* File: hw/dtcr_top.v */
// second timer module: auxiliary and core timer, capture/reload, APB
// Function
// [R1] fastest internal count resolution is two system clocks
// [R2] separate auxiliary timer, core timer and capture/reload register
// [R3] each timer counts prescaled clock or external signal per configuration
// [R4] direction from software bit, optionally altered by external pin level
// [R5] auxiliary timer has no direction pin; software only
// [R6] core toggle latch inverts on every core overflow or underflow
// [R7] toggle latch may clock auxiliary timer and drive output pin
// [R8] core overflow/underflow offered as count clock to compare timers
// [R9] enabled core overflow/underflow triggers reload from capture register
// [R10] selected capture pin edge latches auxiliary timer value
// [R11] optional clear of auxiliary timer right after capture
// [R12] capture also triggerable by first module count/direction inputs
// [R13] both timers are sixteen bits wide
// [R14] reload puts capture/reload value into core timer
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_defs.vh"
module dtcr_top (
	input wire clk_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [`DTCR_ADDR_W-1:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire aux_count_input_i,
	input wire core_count_input_i,
	input wire external_direction_input_i,
	input wire capture_input_pin_i,
	input wire first_module_core_count_input_i,
	input wire first_module_core_direction_input_i,
	output reg toggle_latch_output_pin_o,
	output reg core_wrap_event_o,
	output wire irq_o
);
	reg [`DTCR_CTRL_W-1:0] aux_ctrl_q;
	reg [`DTCR_CTRL_W-1:0] core_ctrl_q;
	reg [`DTCR_CAP_CTRL_W-1:0] cap_ctrl_q;
	reg [`DTCR_W-1:0] capture_reload_register_q;
	reg [`DTCR_IRQ_W-1:0] stat_q;
	reg [`DTCR_IRQ_W-1:0] mask_q;
	reg otl_q;
	reg otl_rise;
	reg otl_fall;
	wire [`DTCR_W-1:0] aux_cnt;
	wire [`DTCR_W-1:0] core_cnt;
	wire aux_wrap;
	wire core_wrap;
	wire ax_r, ax_f, cx_r, cx_f, dir_lvl;
	wire cp_r, cp_f, fi_r, fi_f, fd_r, fd_f;
	wire wr;
	wire rd_hit;
	reg cap_evt;
	wire [1:0] cap_src;
	wire [1:0] cap_edge;
	wire wr_aux_cnt, wr_core_cnt, wr_capture_reload_register;
	wire [`DTCR_IRQ_W-1:0] evt;

	dtcr_sync u_sync_ax (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(aux_count_input_i), .level_o(), .rise_o(ax_r),
		.fall_o(ax_f));
	dtcr_sync u_sync_cx (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(core_count_input_i), .level_o(), .rise_o(cx_r),
		.fall_o(cx_f));
	dtcr_sync u_sync_dir (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(external_direction_input_i), .level_o(dir_lvl),
		.rise_o(), .fall_o());
	dtcr_sync u_sync_cp (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(capture_input_pin_i), .level_o(), .rise_o(cp_r),
		.fall_o(cp_f));
	dtcr_sync u_sync_fi (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(first_module_core_count_input_i), .level_o(),
		.rise_o(fi_r), .fall_o(fi_f));
	dtcr_sync u_sync_fd (.clk_i(clk_i), .srst_i(srst_i),
		.async_i(first_module_core_direction_input_i), .level_o(),
		.rise_o(fd_r), .fall_o(fd_f));

	// apb: zero wait states, no error answers
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign wr = psel_i && penable_i && pwrite_i;
	assign wr_aux_cnt = wr && (paddr_i == `DTCR_A_AUX_CNT);
	assign wr_core_cnt = wr && (paddr_i == `DTCR_A_CORE_CNT);
	assign wr_capture_reload_register = wr && (paddr_i == `DTCR_A_CAPTURE_RELOAD_REGISTER);
	assign rd_hit = psel_i && !penable_i && !pwrite_i;

	// capture trigger selection
	assign cap_src = cap_ctrl_q[`DTCR_F_CAP_SRC_HI:`DTCR_F_CAP_SRC_LO];
	assign cap_edge = cap_ctrl_q[`DTCR_F_CAP_EDGE_HI:`DTCR_F_CAP_EDGE_LO];
	always @* begin
		cap_evt = 1'b0;
		if (cap_src == `DTCR_CSRC_PIN)
			cap_evt = (cap_edge[0] && cp_r) || (cap_edge[1] && cp_f); // [R10]
		else if (cap_src == `DTCR_CSRC_FIN)
			cap_evt = fi_r || fi_f; // [R12]
		else if (cap_src == `DTCR_CSRC_FDIR)
			cap_evt = fd_r || fd_f; // [R12]
		else
			cap_evt = fi_r || fi_f || fd_r || fd_f; // [R12]
	end

	// auxiliary timer: no direction pin, software direction only
	dtcr_timer u_aux (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ctrl_i(aux_ctrl_q),
		.ext_rise_i(ax_r),
		.ext_fall_i(ax_f),
		.dir_lvl_i(1'b0), // [R5]
		.otl_rise_i(otl_rise),
		.otl_fall_i(otl_fall),
		.load_i(wr_aux_cnt),
		.load_val_i(pwdata_i[`DTCR_W-1:0]),
		.clear_i(cap_evt && cap_ctrl_q[`DTCR_F_CAP_CLR]), // [R11]
		.count_o(aux_cnt),
		.wrap_o(aux_wrap)
	); // [R2]

	// core timer: reload on wrap when enabled
	dtcr_timer u_core (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ctrl_i(core_ctrl_q),
		.ext_rise_i(cx_r),
		.ext_fall_i(cx_f),
		.dir_lvl_i(dir_lvl),
		.otl_rise_i(1'b0),
		.otl_fall_i(1'b0),
		.load_i(wr_core_cnt ||
			(core_wrap && core_ctrl_q[`DTCR_F_RLD_EN])), // [R9]
		.load_val_i(wr_core_cnt ? pwdata_i[`DTCR_W-1:0] : capture_reload_register_q), // [R14]
		.clear_i(1'b0),
		.count_o(core_cnt),
		.wrap_o(core_wrap)
	); // [R2]

	// toggle latch and its edges, registered for the aux clock source
	always @(posedge clk_i) begin
		if (srst_i) begin
			otl_q <= 1'b0;
			otl_rise <= 1'b0;
			otl_fall <= 1'b0;
			toggle_latch_output_pin_o <= 1'b0;
			core_wrap_event_o <= 1'b0;
		end else begin
			if (core_wrap)
				otl_q <= !otl_q; // [R6]
			otl_rise <= core_wrap && !otl_q;
			otl_fall <= core_wrap && otl_q;
			toggle_latch_output_pin_o <= core_ctrl_q[`DTCR_F_OUT_EN] &&
				(core_wrap ? !otl_q : otl_q); // [R7]
			core_wrap_event_o <= core_wrap; // [R8]
		end
	end

	// capture register: capture beats a same-cycle software write
	always @(posedge clk_i) begin
		if (srst_i)
			capture_reload_register_q <= {`DTCR_W{1'b0}};
		else if (cap_evt)
			capture_reload_register_q <= aux_cnt; // [R10]
		else if (wr_capture_reload_register)
			capture_reload_register_q <= pwdata_i[`DTCR_W-1:0];
	end

	// control registers
	always @(posedge clk_i) begin
		if (srst_i) begin
			aux_ctrl_q <= {`DTCR_CTRL_W{1'b0}};
			core_ctrl_q <= {`DTCR_CTRL_W{1'b0}};
			cap_ctrl_q <= {`DTCR_CAP_CTRL_W{1'b0}};
			mask_q <= {`DTCR_IRQ_W{1'b0}};
		end else if (wr) begin
			if (paddr_i == `DTCR_A_AUX_CTRL)
				aux_ctrl_q <= pwdata_i[`DTCR_CTRL_W-1:0];
			else if (paddr_i == `DTCR_A_CORE_CTRL)
				core_ctrl_q <= pwdata_i[`DTCR_CTRL_W-1:0];
			else if (paddr_i == `DTCR_A_CAP_CTRL)
				cap_ctrl_q <= pwdata_i[`DTCR_CAP_CTRL_W-1:0];
			else if (paddr_i == `DTCR_A_IRQ_MASK)
				mask_q <= pwdata_i[`DTCR_IRQ_W-1:0];
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	assign evt = {cap_evt, core_wrap, aux_wrap};
	always @(posedge clk_i) begin
		if (srst_i)
			stat_q <= {`DTCR_IRQ_W{1'b0}};
		else if (wr && (paddr_i == `DTCR_A_IRQ_STAT))
			stat_q <= (stat_q & ~pwdata_i[`DTCR_IRQ_W-1:0]) | evt;
		else
			stat_q <= stat_q | evt;
	end
	assign irq_o = |(stat_q & mask_q);

	// read data registered in setup so it stands through the access phase
	always @(posedge clk_i) begin
		if (srst_i)
			prdata_o <= 32'h00000000;
		else if (rd_hit) begin
			if (paddr_i == `DTCR_A_AUX_CTRL)
				prdata_o <= {20'h00000, aux_ctrl_q};
			else if (paddr_i == `DTCR_A_CORE_CTRL)
				prdata_o <= {20'h00000, core_ctrl_q};
			else if (paddr_i == `DTCR_A_AUX_CNT)
				prdata_o <= {16'h0000, aux_cnt};
			else if (paddr_i == `DTCR_A_CORE_CNT)
				prdata_o <= {15'h0000, otl_q, core_cnt};
			else if (paddr_i == `DTCR_A_CAPTURE_RELOAD_REGISTER)
				prdata_o <= {16'h0000, capture_reload_register_q};
			else if (paddr_i == `DTCR_A_CAP_CTRL)
				prdata_o <= {27'h0000000, cap_ctrl_q};
			else if (paddr_i == `DTCR_A_IRQ_STAT)
				prdata_o <= {29'h00000000, stat_q};
			else if (paddr_i == `DTCR_A_IRQ_MASK)
				prdata_o <= {29'h00000000, mask_q};
			else
				prdata_o <= 32'h00000000;
		end
	end
endmodule // dtcr_top
`default_nettype wire

/* File: dv/dtcr_top_sva.sv */
// port checker for the dual timer block
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_defs.vh"
module dtcr_top_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`DTCR_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic toggle_latch_output_pin_o,
	input wire logic core_wrap_event_o,
	input wire logic irq_o
);
	logic out_en_q;
	logic [`DTCR_IRQ_W-1:0] mask_q;
	wire wr_w = psel_i && penable_i && pwrite_i;
	// shadow copies of the output enable bit and the interrupt mask, taken from the bus itself
	always @(posedge clk_i) begin
		if (srst_i) begin
			out_en_q <= 1'b0;
			mask_q <= 3'h0;
		end else if (wr_w && paddr_i == `DTCR_A_CORE_CTRL) begin
			out_en_q <= pwdata_i[`DTCR_F_OUT_EN];
		end else if (wr_w && paddr_i == `DTCR_A_IRQ_MASK) begin
			mask_q <= pwdata_i[`DTCR_IRQ_W-1:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_BUS_ANSWER: assert property (pready_o && !pslverr_o)
		else $error("bus answer late or in error");
	AST_WRAP_PULSE: assert property (core_wrap_event_o |=>
		!core_wrap_event_o) else $error("wrap pulse longer than one cycle");
	AST_RST_CLEAN: assert property ($fell(srst_i) |->
		!irq_o && !toggle_latch_output_pin_o && !core_wrap_event_o)
		else $error("outputs not clear after reset");
	AST_RD_HOLD: assert property (!$past(srst_i) &&
		!$past(psel_i && !penable_i && !pwrite_i) |-> $stable(prdata_o))
		else $error("read data moved without a read");
	AST_OTL_TOGGLE: assert property (core_wrap_event_o && out_en_q &&
		$past(out_en_q) |-> ##[0:2] $changed(toggle_latch_output_pin_o))
		else $error("latch pin kept level across a wrap");
	AST_PIN_OFF: assert property (!out_en_q && !$past(out_en_q) |->
		!toggle_latch_output_pin_o) else $error("latch pin driven while off");
	AST_IRQ_MASKED: assert property (mask_q == 3'h0 |-> !irq_o)
		else $error("interrupt with all sources masked");
	AST_UNMAPPED: assert property (psel_i && penable_i && !pwrite_i &&
		paddr_i > `DTCR_A_IRQ_MASK |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	COV_WRAP: cover property (core_wrap_event_o && out_en_q);
	COV_IRQ: cover property (irq_o);
	COV_OTL: cover property ($rose(toggle_latch_output_pin_o));
endmodule // dtcr_top_sva
bind dtcr_top dtcr_top_sva dtcr_top_sva_i (.clk_i, .srst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .toggle_latch_output_pin_o, .core_wrap_event_o, .irq_o);
`default_nettype wire

/* File: dv/dtcr_pins_model.sv */
// pin-side model: count, direction and capture pins of the block
`timescale 1ns/1ps
`default_nettype none
module dtcr_pins_model (
	input wire logic clk_i,
	output logic [5:0] pins_o
);
	initial pins_o = 6'h00;
	// each level held 6 clocks: the pin filter wants 2 stable clocks
	task automatic set_pin(input int idx, input logic val);
		@(posedge clk_i);
		pins_o[idx] <= val;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic pulse(input int idx);
		set_pin(idx, 1'b1);
		set_pin(idx, 1'b0);
	endtask
endmodule // dtcr_pins_model
`default_nettype wire

/* File: dv/test_dual_timer_capture_reload.sv */
// testbench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_defs.vh"
module test_dual_timer_capture_reload;
	logic clk_i, srst_i, psel_i, penable_i, pwrite_i, p;
	logic [`DTCR_ADDR_W-1:0] paddr_i;
	logic [31:0] pwdata_i, r, v;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, toggle_latch_output_pin_o, core_wrap_event_o, irq_o;
	wire [5:0] pins;
	int mismatches = 0, comparisons = 0, cyc = 0, n;
	logic [11:0] cfg [4] = '{12'hC01, 12'hC03, 12'hC05, 12'hC21};
	dtcr_top dtcr_top_i (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .aux_count_input_i(pins[0]),
		.core_count_input_i(pins[1]), .external_direction_input_i(pins[2]),
		.capture_input_pin_i(pins[3]), .first_module_core_count_input_i(pins[4]),
		.first_module_core_direction_input_i(pins[5]),
		.toggle_latch_output_pin_o(toggle_latch_output_pin_o),
		.core_wrap_event_o(core_wrap_event_o), .irq_o(irq_o));
	dtcr_pins_model dtcr_pins_model_i (.clk_i(clk_i), .pins_o(pins));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	// bounded wait for the next wrap pulse, counted on falling edges
	task automatic ww();
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (core_wrap_event_o !== 1'b1 && n < 100);
	endtask
	initial begin
		srst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 9; i++) rd(12'(4 * i), 32'h0);
		wr(`DTCR_A_AUX_CNT, 32'hFFFFFFFF);
		rd(`DTCR_A_AUX_CNT, 32'h0000FFFF);
		$display("test registers done");
		wr(`DTCR_A_IRQ_MASK, 32'h2);
		for (int i = 0; i < 4; i++) begin
			v = (cfg[i][1] || cfg[i][2]) ? 32'h1 : 32'hFFFE;
			dtcr_pins_model_i.set_pin(2, cfg[i][2]);
			wr(`DTCR_A_CAPTURE_RELOAD_REGISTER, v);
			wr(`DTCR_A_CORE_CNT, v);
			wr(`DTCR_A_CORE_CTRL, {20'h0, cfg[i]});
			ww();
			@(negedge clk_i);
			p = toggle_latch_output_pin_o;
			ww();
			// two ticks per reload, a tick is 2 << prescale clocks
			chk(32'(n), cfg[i][5] ? 32'h7 : 32'h3);
			@(negedge clk_i);
			chk(toggle_latch_output_pin_o, !p);
		end
		wr(`DTCR_A_CORE_CTRL, 32'h0);
		@(negedge clk_i);
		chk(irq_o, 32'h1);
		wr(`DTCR_A_IRQ_STAT, 32'h2);
		rd(`DTCR_A_IRQ_STAT, 32'h0);
		$display("test core done");
		wr(`DTCR_A_AUX_CNT, 32'h1234);
		wr(`DTCR_A_CAP_CTRL, 32'h5);
		dtcr_pins_model_i.pulse(3);
		rd(`DTCR_A_CAPTURE_RELOAD_REGISTER, 32'h1234);
		rd(`DTCR_A_AUX_CNT, 32'h0);
		for (int s = 1; s < 4; s++) begin
			wr(`DTCR_A_AUX_CNT, 32'h50 + s);
			wr(`DTCR_A_CAP_CTRL, 32'(s << 3));
			dtcr_pins_model_i.pulse(s == 2 ? 5 : 4);
			rd(`DTCR_A_CAPTURE_RELOAD_REGISTER, 32'h50 + s);
		end
		rd(`DTCR_A_IRQ_STAT, 32'h4);
		@(negedge clk_i);
		chk(irq_o, 32'h0);
		wr(`DTCR_A_IRQ_MASK, 32'h6);
		@(negedge clk_i);
		chk(irq_o, 32'h1);
		wr(`DTCR_A_IRQ_STAT, 32'h4);
		@(negedge clk_i);
		chk(irq_o, 32'h0);
		$display("test capture done");
		// direction pin high must not turn the auxiliary timer round
		wr(`DTCR_A_AUX_CNT, 32'h0);
		wr(`DTCR_A_AUX_CTRL, 32'h10D);
		dtcr_pins_model_i.set_pin(2, 1'b1);
		repeat (3) dtcr_pins_model_i.pulse(0);
		rd(`DTCR_A_AUX_CNT, 32'h3);
		$display("test aux count done");
		// reset in mid-run, so the latch starts from a known level
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		// core on its pin, both edges, no reload; aux on the latch
		wr(`DTCR_A_CAPTURE_RELOAD_REGISTER, 32'h1234);
		wr(`DTCR_A_AUX_CNT, 32'hFFFF);
		wr(`DTCR_A_CORE_CNT, 32'hFFFF);
		wr(`DTCR_A_AUX_CTRL, 32'h11);
		wr(`DTCR_A_CORE_CTRL, 32'hB09);
		dtcr_pins_model_i.pulse(1);
		rd(`DTCR_A_CORE_CNT, 32'h00010001);
		rd(`DTCR_A_AUX_CNT, 32'h0);
		rd(`DTCR_A_IRQ_STAT, 32'h3);
		chk(toggle_latch_output_pin_o, 32'h1);
		$display("test latch clock done");
		complete_run();
	end
endmodule // test_dual_timer_capture_reload
`default_nettype wire
